/* File: board_clk_wake.sv */
// Purpose: Board model: select strap, two clock sources, wake line.
// Assumes: The bench moves the strap only while reset is held.
// Notes:   Wake line has a pull-up and is open drain on both sides.
`timescale 1ns/10ps
module board_clk_wake (
	input wire logic i_clk,
	input wire logic i_strap,
	input wire logic i_pull_low,
	input wire logic i_dev_out,
	input wire logic i_dev_oe,
	output logic o_strap,
	output logic o_osc_32k,
	output logic o_ext_ref,
	output logic o_wake_line
);
	int cnt = 0;
	// Strap is a static level from the board
	assign o_strap = i_strap;
	// Slow and fast sources, moved just after the edge
	always @(posedge i_clk)
	begin
		cnt <= cnt + 1;
		o_osc_32k <= #1 cnt[3];
		o_ext_ref <= #1 cnt[0];
	end
	// Pulled high unless either party sinks the line
	assign o_wake_line = ((i_dev_oe && !i_dev_out) || i_pull_low) ?
		1'b0 : 1'b1;
endmodule // board_clk_wake

/* File: clk_rtc_pins.sv */
// Purpose: Clock source select, boot clock setup, RTC window gate,
//          RTC clock output pin and wake pin control.
// Assumes: Pins sampled on i_core_clk; clocks seen here as levels.
// Notes:   The select strap is caught once after reset release.
//
// Behaviour
// - With select low, the 32 kHz oscillator feeds the RTC timer and the system clock generator, and the external reference is ignored.
// - With select high, the external reference feeds the system clock generator while the 32 kHz oscillator feeds only the RTC timer and the RTC clock output pin.
// - With the external reference selected, boot bypasses the PLL assuming one of three supported reference rates.
// - Under that assumption boot sets the SPI clock to at most 500 kHz and the I2C clock to at most 400 kHz.
// - While the RTC oscillator is disabled, the RTC register window in I/O space cannot be reached.
// - The RTC clock output pin is driven only while its enable bit is set and floats otherwise.
// - After reset the RTC clock output pin stays floating until software enables it.
// - A wake pin assertion while the pin is an input brings the core out of idle.
// - The wake pin comes up as an input and can become an active-low open-drain alarm output.
`timescale 1ns/10ps
module clk_rtc_pins #(
	parameter int unsigned REF_HZ = clk_rtc_pins_pkg::REF_HZ_B
) (
	input wire logic i_core_clk,
	input wire logic i_rstn,
	input wire logic i_clock_source_select,
	input wire logic i_rtc_osc_32k,
	input wire logic i_external_reference_clock_in,
	input wire logic i_rtc_osc_enabled,
	input wire logic i_rtc_clock_output_enable,
	input wire logic i_wake_output_mode,
	input wire logic i_rtc_alarm,
	input wire logic i_rtc_alarm_clear,
	input wire logic i_io_req,
	input wire logic [15:0] i_io_addr,
	input wire logic i_wake_pin_in,
	output logic o_sysclk_src_ext,
	output logic o_sysclk_ref,
	output logic o_rtc_timer_clk,
	output logic o_boot_pll_bypass,
	output logic [clk_rtc_pins_pkg::DIV_W-1:0] o_spi_boot_div,
	output logic [clk_rtc_pins_pkg::DIV_W-1:0] o_i2c_boot_div,
	output logic o_rtc_window_hit,
	output logic o_rtc_access_grant,
	output logic o_rtc_clock_output_pin,
	output logic o_rtc_clock_output_pin_oe,
	output logic o_wake_pin_out,
	output logic o_wake_pin_oe,
	output logic o_core_wake_req,
	output logic o_alarm_pending
);
	localparam int unsigned SPI_DIV_I =
		(REF_HZ + clk_rtc_pins_pkg::SPI_BOOT_HZ - 1) /
		clk_rtc_pins_pkg::SPI_BOOT_HZ;
	localparam int unsigned I2C_DIV_I =
		(REF_HZ + clk_rtc_pins_pkg::I2C_BOOT_HZ - 1) /
		clk_rtc_pins_pkg::I2C_BOOT_HZ;
	localparam logic [clk_rtc_pins_pkg::DIV_W-1:0] SPI_DIV =
		SPI_DIV_I[clk_rtc_pins_pkg::DIV_W-1:0];
	localparam logic [clk_rtc_pins_pkg::DIV_W-1:0] I2C_DIV =
		I2C_DIV_I[clk_rtc_pins_pkg::DIV_W-1:0];

	logic [4:0] pins_s;
	logic sel_s;
	logic osc_s;
	logic ref_s;
	logic osc_en_s;
	logic wake_s;
	logic sel_q;
	logic sel_caught_q;
	logic [1:0] settle_q;
	logic clkout_en_q;
	logic wake_mode_q;
	logic wake_prev_q;
	logic alarm_q;
	logic in_window;

	// Every pin input crosses two flip-flops first
	pin_sync2 #(
		.WIDTH(5),
		.RST_VAL({clk_rtc_pins_pkg::WAKE_IDLE_LVL, 4'h0})
	) u_pin_sync (
		.i_core_clk(i_core_clk),
		.i_rstn(i_rstn),
		.i_async({i_wake_pin_in, i_rtc_osc_enabled,
			i_external_reference_clock_in, i_rtc_osc_32k,
			i_clock_source_select}),
		.o_sync(pins_s)
	);
	assign sel_s = pins_s[0];
	assign osc_s = pins_s[1];
	assign ref_s = pins_s[2];
	assign osc_en_s = pins_s[3];
	assign wake_s = pins_s[4];

	// Strap caught once, only after the synchroniser has left reset
	// and holds the real pin; later pin motion is ignored by design
	always_ff @(posedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			sel_q <= clk_rtc_pins_pkg::SYNC_RST;
			sel_caught_q <= 1'b0;
			settle_q <= 2'h0;
		end
		else if (!sel_caught_q)
		begin
			if (settle_q == clk_rtc_pins_pkg::STRAP_SETTLE)
			begin
				sel_q <= sel_s;
				sel_caught_q <= 1'b1;
			end
			else
				settle_q <= settle_q + 2'h1;
		end
	end

	// Clock source routing; external ref ignored while select low
	always_ff @(posedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_sysclk_ref <= 1'b0;
			o_rtc_timer_clk <= 1'b0;
			o_sysclk_src_ext <= 1'b0;
		end
		else
		begin
			o_sysclk_ref <= sel_q ? ref_s : osc_s;
			o_rtc_timer_clk <= osc_s;
			o_sysclk_src_ext <= sel_q;
		end
	end

	// Boot clocking; divisors round up so rates never overshoot
	always_ff @(posedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_boot_pll_bypass <= 1'b0;
			o_spi_boot_div <= '0;
			o_i2c_boot_div <= '0;
		end
		else
		begin
			o_boot_pll_bypass <= sel_q;
			o_spi_boot_div <= sel_q ? SPI_DIV : '0;
			o_i2c_boot_div <= sel_q ? I2C_DIV : '0;
		end
	end

	// RTC window gate, combinational so the access is never stalled
	assign in_window = (i_io_addr >= clk_rtc_pins_pkg::RTC_WIN_LO) &&
		(i_io_addr <= clk_rtc_pins_pkg::RTC_WIN_HI);
	assign o_rtc_window_hit = i_io_req && in_window;
	assign o_rtc_access_grant = o_rtc_window_hit && osc_en_s;

	// RTC clock output enable; floats from reset
	always_ff @(posedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			clkout_en_q <= clk_rtc_pins_pkg::CLKOUT_EN_RST;
			o_rtc_clock_output_pin <= 1'b0;
		end
		else
		begin
			clkout_en_q <= i_rtc_clock_output_enable;
			o_rtc_clock_output_pin <= osc_s;
		end
	end
	assign o_rtc_clock_output_pin_oe = clkout_en_q;

	// Wake pin direction; comes up as an input
	always_ff @(posedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			wake_mode_q <= clk_rtc_pins_pkg::WAKE_MODE_RST;
		else
			wake_mode_q <= i_wake_output_mode;
	end

	// Alarm flag; a new alarm beats a simultaneous clear
	always_ff @(posedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			alarm_q <= 1'b0;
		else if (i_rtc_alarm)
			alarm_q <= 1'b1;
		else if (i_rtc_alarm_clear)
			alarm_q <= 1'b0;
	end
	assign o_alarm_pending = alarm_q;

	// Open drain: only ever pull low
	assign o_wake_pin_out = 1'b0;
	assign o_wake_pin_oe = wake_mode_q && alarm_q;

	// Wake request on a falling edge of the synced pin, input mode only
	always_ff @(posedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			wake_prev_q <= clk_rtc_pins_pkg::WAKE_IDLE_LVL;
			o_core_wake_req <= 1'b0;
		end
		else
		begin
			wake_prev_q <= wake_s;
			o_core_wake_req <= !wake_mode_q && wake_prev_q && !wake_s;
		end
	end

	a_sel_low_route: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn)
		(sel_caught_q && !sel_q) |=> (o_sysclk_ref == $past(osc_s)))
		else $error("system ref not from 32k osc");

	a_sel_high_route: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn)
		(sel_caught_q && sel_q) |=>
			(o_sysclk_ref == $past(ref_s)) &&
			(o_rtc_timer_clk == $past(osc_s)))
		else $error("system ref not from external clock");

	a_strap_held: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn)
		sel_caught_q |=> $stable(sel_q))
		else $error("captured select moved");

	a_pll_bypass: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn)
		(sel_caught_q && sel_q) |=> o_boot_pll_bypass)
		else $error("PLL not bypassed on external ref");

	a_boot_divs: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn)
		o_boot_pll_bypass |->
			(o_spi_boot_div == SPI_DIV) && (o_i2c_boot_div == I2C_DIV))
		else $error("boot serial divisors wrong");

	a_window_block: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn)
		(!osc_en_s || !in_window) |-> !o_rtc_access_grant)
		else $error("RTC window reached with osc off");

	a_clkout_gate: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn)
		!i_rtc_clock_output_enable |=> !o_rtc_clock_output_pin_oe)
		else $error("clock out driven while disabled");

	a_clkout_reset: assert property (
		@(posedge i_core_clk)
		!i_rstn |-> !o_rtc_clock_output_pin_oe && !o_wake_pin_oe)
		else $error("pin driven during reset");

	a_wake_core: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn)
		(!wake_mode_q && $fell(wake_s)) |=> o_core_wake_req)
		else $error("wake edge did not wake core");

	a_wake_pulse: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn)
		o_core_wake_req |=> !o_core_wake_req)
		else $error("wake request longer than one cycle");

	a_wake_drive: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn)
		o_wake_pin_oe |-> wake_mode_q && alarm_q && !o_wake_pin_out)
		else $error("wake pin driven wrongly");

	a_wake_sync: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn)
		$fell(i_wake_pin_in) ##1 !i_wake_pin_in |-> wake_s ##1 !wake_s)
		else $error("wake pin not through two stages");
endmodule // clk_rtc_pins

/* File: clk_rtc_pins_pkg.sv */
// Purpose: Shared constants for the clock select and RTC pin block,
//          plus the two-stage synchroniser used for every pin input.
// Assumes: One core clock; all pins asynchronous to it.
// Notes:   Boot clock divisors round up so serial clocks never exceed
//          their target rate.
`timescale 1ns/10ps
package clk_rtc_pins_pkg;
	// Assumed external reference rates, in Hz
	localparam int unsigned REF_HZ_A = 11_289_600;
	localparam int unsigned REF_HZ_B = 12_000_000;
	localparam int unsigned REF_HZ_C = 12_288_000;
	// Boot serial clock targets, in Hz
	localparam int unsigned SPI_BOOT_HZ = 500_000;
	localparam int unsigned I2C_BOOT_HZ = 400_000;
	localparam int DIV_W = 8;
	// RTC register window in I/O space
	localparam logic [15:0] RTC_WIN_LO = 16'h1900;
	localparam logic [15:0] RTC_WIN_HI = 16'h197f;
	// Reset values
	localparam logic CLKOUT_EN_RST = 1'b0;
	localparam logic WAKE_MODE_RST = 1'b0; // 0 = input
	localparam logic SYNC_RST = 1'b0;
	// Edges the strap needs to fill the synchroniser before capture
	localparam logic [1:0] STRAP_SETTLE = 2'h2;
	// Pin-side wake level when idle (pulled up, active low)
	localparam logic WAKE_IDLE_LVL = 1'b1;
endpackage

// Purpose: Two flip-flop synchroniser, one bit per lane.
// Assumes: Inputs asynchronous to i_core_clk.
// Notes:   First stage is read only by the second stage.
module pin_sync2 #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic i_core_clk,
	input wire logic i_rstn,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta_q;

	// Both stages reset to a constant
	always_ff @(posedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			meta_q <= RST_VAL;
			o_sync <= RST_VAL;
		end
		else
		begin
			meta_q <= i_async;
			o_sync <= meta_q;
		end
	end
endmodule // pin_sync2

/* File: tb_top.sv */
// Purpose: Self-checking bench for clock select and RTC pin control.
// Assumes: Board model supplies strap, clocks and the wake line.
// Notes:   Expected values come from integer sums and a history queue.
`timescale 1ns/10ps
module tb_top;
	localparam int unsigned REF = clk_rtc_pins_pkg::REF_HZ_C;
	logic i_core_clk = 1'b0;
	logic i_rstn;
	logic strap = 1'b0;
	logic pull_low = 1'b0;
	logic i_rtc_osc_enabled = 1'b0;
	logic i_rtc_clock_output_enable = 1'b0;
	logic i_wake_output_mode = 1'b0;
	logic i_rtc_alarm = 1'b0;
	logic i_rtc_alarm_clear = 1'b0;
	logic i_io_req = 1'b0;
	logic [15:0] i_io_addr = 16'h0000;
	logic i_clock_source_select, i_rtc_osc_32k;
	logic i_external_reference_clock_in, i_wake_pin_in;
	logic o_sysclk_src_ext, o_sysclk_ref, o_rtc_timer_clk;
	logic o_boot_pll_bypass, o_rtc_window_hit, o_rtc_access_grant;
	logic o_rtc_clock_output_pin, o_rtc_clock_output_pin_oe;
	logic o_wake_pin_out, o_wake_pin_oe, o_core_wake_req, o_alarm_pending;
	logic [7:0] o_spi_boot_div, o_i2c_boot_div;
	int n_mismatch = 0;
	int cmp_count = 0;
	int n_req = 0;
	int k;
	logic osc_h[$];
	logic ext_h[$];
	always #5 i_core_clk = ~i_core_clk;
	board_clk_wake i_board_clk_wake (.i_clk(i_core_clk), .i_strap(strap),
		.i_pull_low(pull_low), .i_dev_out(o_wake_pin_out),
		.i_dev_oe(o_wake_pin_oe), .o_strap(i_clock_source_select),
		.o_osc_32k(i_rtc_osc_32k), .o_ext_ref(i_external_reference_clock_in),
		.o_wake_line(i_wake_pin_in));
	clk_rtc_pins #(.REF_HZ(REF)) i_clk_rtc_pins (.i_core_clk, .i_rstn,
		.i_clock_source_select, .i_rtc_osc_32k, .i_external_reference_clock_in,
		.i_rtc_osc_enabled, .i_rtc_clock_output_enable, .i_wake_output_mode,
		.i_rtc_alarm, .i_rtc_alarm_clear, .i_io_req, .i_io_addr, .i_wake_pin_in,
		.o_sysclk_src_ext, .o_sysclk_ref, .o_rtc_timer_clk, .o_boot_pll_bypass,
		.o_spi_boot_div, .o_i2c_boot_div, .o_rtc_window_hit,
		.o_rtc_access_grant, .o_rtc_clock_output_pin,
		.o_rtc_clock_output_pin_oe, .o_wake_pin_out, .o_wake_pin_oe,
		.o_core_wake_req, .o_alarm_pending);
	// Source history, newest first; outputs lag two edges behind it
	always @(posedge i_core_clk)
	begin
		osc_h.push_front(i_rtc_osc_32k);
		ext_h.push_front(i_external_reference_clock_in);
		if (osc_h.size() > 4)
		begin
			void'(osc_h.pop_back());
			void'(ext_h.pop_back());
		end
		if (o_core_wake_req === 1'b1)
			n_req++;
	end
	task automatic stop_test;
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp,
		input string what);
		cmp_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: %s", $time, what);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge i_core_clk);
		#1;
	endtask
	// Strap only moves under reset, as the board must keep it
	task automatic do_reset(input logic s);
		i_rstn = 1'b0;
		strap = s;
		cyc(3);
		chk(o_rtc_clock_output_pin_oe, 1'b0, "clock out oe");
		chk(o_wake_pin_oe, 1'b0, "wake oe");
		i_rstn = 1'b1;
		cyc(4);
		chk(o_rtc_clock_output_pin_oe, 1'b0, "clock out oe after");
		chk(o_sysclk_src_ext, s, "source select");
		chk(o_boot_pll_bypass, s, "pll bypass");
		chk(o_spi_boot_div, s ? 8'((REF + 499999) / 500000) : 8'h00, "spi");
		chk(o_i2c_boot_div, s ? 8'((REF + 399999) / 400000) : 8'h00, "i2c");
		for (k = 0; k < 20; k++)
		begin
			chk(o_sysclk_ref, s ? ext_h[2] : osc_h[2], "sys ref");
			chk(o_rtc_timer_clk, osc_h[2], "rtc timer clock");
			cyc(1);
		end
	endtask
	task automatic io_chk(input logic [15:0] a, input logic en, input logic r);
		logic in_win;
		i_io_req = r;
		i_io_addr = a;
		in_win = r && (a >= 16'h1900) && (a <= 16'h197f);
		#1;
		chk(o_rtc_window_hit, in_win, "window hit");
		chk(o_rtc_access_grant, in_win && en, "window grant");
		cyc(1);
	endtask
	// Falling wake line: pulse after the third sampling edge, input mode
	task automatic wake_in(input logic m);
		i_wake_output_mode = m;
		cyc(2);
		n_req = 0;
		pull_low = 1'b1;
		cyc(2);
		chk(8'(n_req), 8'h00, "wake before sync");
		chk(o_core_wake_req, 1'b0, "wake too early");
		cyc(1);
		chk(o_core_wake_req, !m, "wake pulse");
		cyc(5);
		pull_low = 1'b0;
		chk(8'(n_req), 8'(!m), "wake pulse count");
		cyc(4);
	endtask
	task automatic wake_out(input logic m, input logic clr);
		i_wake_output_mode = m;
		cyc(1);
		i_rtc_alarm = 1'b1;
		i_rtc_alarm_clear = clr;
		cyc(1);
		i_rtc_alarm = 1'b0;
		i_rtc_alarm_clear = 1'b0;
		chk(o_alarm_pending, 1'b1, "alarm flag");
		cyc(3);
		chk(o_wake_pin_oe, m, "wake drive");
		chk(i_wake_pin_in, !m, "wake line");
		chk(o_wake_pin_out, 1'b0, "wake low level");
		i_rtc_alarm_clear = 1'b1;
		cyc(1);
		i_rtc_alarm_clear = 1'b0;
		chk(o_alarm_pending | o_wake_pin_oe, 1'b0, "alarm clear");
	endtask
	// Sequence takes about 155 cycles; watchdog allows some 130 times that
	initial
	begin
		#200000;
		n_mismatch++;
		stop_test();
	end
	initial
	begin
		void'($urandom(81915));
		do_reset(1'b0);
		do_reset(1'b1);
		for (k = 0; k < 2; k++)
		begin
			i_rtc_osc_enabled = k[0];
			cyc(3);
			io_chk(16'h18ff, k[0], 1'b1);
			io_chk(16'h1900, k[0], 1'b1);
			io_chk(16'h197f, k[0], 1'b1);
			io_chk(16'h1980, k[0], 1'b1);
			io_chk(16'h1940, k[0], 1'b0);
			repeat (8)
				io_chk(16'(16'h1880 + $urandom_range(0, 255)), k[0], 1'b1);
		end
		i_rtc_clock_output_enable = 1'b1;
		cyc(1);
		for (k = 0; k < 20; k++)
		begin
			chk(o_rtc_clock_output_pin_oe, 1'b1, "clock out oe");
			chk(o_rtc_clock_output_pin, osc_h[2], "clock out level");
			cyc(1);
		end
		i_rtc_clock_output_enable = 1'b0;
		cyc(1);
		chk(o_rtc_clock_output_pin_oe, 1'b0, "clock out off");
		wake_in(1'b0);
		wake_in(1'b1);
		wake_out(1'b1, 1'b0);
		wake_out(1'b1, 1'b1);
		wake_out(1'b0, 1'b0);
		stop_test();
	end
endmodule // tb_top
